// ### pkg/hbp_pkg.sv
// Constants shared by the half-bridge PWM and mode control block.
// Assumes a 20 MHz internal clock and a separate host link clock.
//
// Behaviour
// - Power-on reset clears settings, outputs off
// - Motor supply dropout keeps all settings
// - Enable high gives normal mode, pump on
// - Enable low: sleep, switches off, settings cleared
// - Logic undervoltage: ignore host, clear, outputs off
// - After power-on reset the flag reads 0
// - After enable reset the flag reads 0
// - Enabled switch of a bridge with no channel held steadily on, unmodulated
// - Three PWM channels with 8-bit duty
// - Codes 01/10/11 give 80/100/200 Hz
// - Code zero stops channel; nonzero starts period
// - Running changes applied glitch-free at period end
// - Free-wheel selectable, passive after reset
// - Active free-wheel needs both on-times above deadtimes
// - Active free-wheel: complement conducts in off phase
// - Two-bit bridge field assigns channel or none
// - Stopped active-fw high switch: low switch on
package hbp_pkg;
    // ------------------------------------------------------------
    // Clock and structure
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int NB = 8;
    localparam int NCH = 3;
    localparam int STEPS = 256;
    localparam logic [7:0] STEP_LAST = 8'hFF;
    localparam logic [7:0] GAP_MAX = 8'hFF;

    // ------------------------------------------------------------
    // Frequency codes and rates
    // ------------------------------------------------------------
    localparam logic [1:0] FRQ_OFF = 2'h0;
    localparam logic [1:0] FRQ_80 = 2'h1;
    localparam logic [1:0] FRQ_100 = 2'h2;
    localparam logic [1:0] FRQ_200 = 2'h3;
    localparam int HZ_80 = 80;
    localparam int HZ_100 = 100;
    localparam int HZ_200 = 200;
    // Clocks per duty step; period is STEPS steps
    localparam logic [9:0] PRE_80 = 10'(CLK_HZ / (HZ_80 * STEPS));
    localparam logic [9:0] PRE_100 = 10'(CLK_HZ / (HZ_100 * STEPS));
    localparam logic [9:0] PRE_200 = 10'(CLK_HZ / (HZ_200 * STEPS));

    // ------------------------------------------------------------
    // Dead times (plain defaults, not characterised)
    // ------------------------------------------------------------
    localparam int DT_HL_NS = 1000;
    localparam int DT_LH_NS = 1000;
    localparam logic [7:0] DT_HL_CYC = 8'((DT_HL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DT_LH_CYC = 8'((DT_LH_NS + CLK_NS - 1) / CLK_NS);
    localparam int DT_SUM_CYC = int'(DT_HL_CYC) + int'(DT_LH_CYC);

    // ------------------------------------------------------------
    // Host write indices and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_ACT_HI = 4'h0;
    localparam logic [3:0] IDX_ACT_LO = 4'h1;
    localparam logic [3:0] IDX_SEL_A = 4'h2;
    localparam logic [3:0] IDX_SEL_B = 4'h3;
    localparam logic [3:0] IDX_FREQ = 4'h4;
    localparam logic [3:0] IDX_FW = 4'h5;
    localparam logic [3:0] IDX_DUTY1 = 4'h6;
    localparam logic [3:0] IDX_DUTY2 = 4'h7;
    localparam logic [3:0] IDX_DUTY3 = 4'h8;
    localparam logic [3:0] IDX_FLAG = 4'h9;
    localparam logic [7:0] ACT_RST = 8'h00;
    localparam logic [7:0] FW_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [1:0] SEL_NONE = 2'h0;

    typedef enum logic [1:0] {MODE_OFF, MODE_SLEEP, MODE_NORMAL} hbp_mode_t;

    // Step length for a frequency code
    function automatic logic [9:0] hbp_prescale(input logic [1:0] code);
        logic [9:0] p;
        p = PRE_200;
        if (code == FRQ_80) begin
            p = PRE_80;
        end else if (code == FRQ_100) begin
            p = PRE_100;
        end
        return p;
    endfunction
endpackage

// ### src/hbp_bridge_ctrl.sv
// Mode control, settings and switch drive for eight half-bridges.
// Assumes pins enPin, vddLow, vsFault are asynchronous; host writes
// arrive on linkClk with their own synchronous reset linkRst.
`timescale 1ns/1ps
module hbp_bridge_ctrl
    import hbp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic enPin,
    input wire logic vddLow,
    input wire logic vsFault,
    input wire logic linkClk,
    input wire logic linkRst,
    input wire logic cfgWrite,
    input wire logic [3:0] cfgIndex,
    input wire logic [7:0] cfgData,
    output logic cfgReady,
    output logic [7:0] highSwitch,
    output logic [7:0] lowSwitch,
    output logic chargePumpOn,
    output logic normalMode,
    output logic resetSeenFlag,
    output logic [2:0] chanRunning
);
    // ------------------------------------------------------------
    // Link side: hold one write until the core has taken it
    // ------------------------------------------------------------
    logic reqTgl_q, reqTgl_d; // Flips once per write
    logic [3:0] linkIdx_q, linkIdx_d;
    logic [7:0] linkData_q, linkData_d;
    logic ackS1_q; // First stage, read only by ackS2_q
    logic ackS2_q;
    logic ackSeen_q; // Last toggle taken by the core, written on mclk

    // Accept only when the previous write has been acknowledged
    always_comb begin
        reqTgl_d = reqTgl_q;
        linkIdx_d = linkIdx_q;
        linkData_d = linkData_q;
        if (cfgWrite && cfgReady) begin
            reqTgl_d = ~reqTgl_q;
            linkIdx_d = cfgIndex;
            linkData_d = cfgData;
        end
    end

    // Link registers
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            reqTgl_q <= 1'b0;
            linkIdx_q <= 4'h0;
            linkData_q <= 8'h00;
            ackS1_q <= 1'b0;
            ackS2_q <= 1'b0;
        end else begin
            reqTgl_q <= reqTgl_d;
            linkIdx_q <= linkIdx_d;
            linkData_q <= linkData_d;
            ackS1_q <= ackSeen_q;
            ackS2_q <= ackS1_q;
        end
    end

    assign cfgReady = (reqTgl_q == ackS2_q);

    // ------------------------------------------------------------
    // Core side: synchronisers
    // ------------------------------------------------------------
    logic reqS1_q; // First stage, read only by reqS2_q
    logic reqS2_q;
    logic [2:0] pinS1_q; // First stage of enable, vdd, vs pins
    logic [2:0] pinS2_q;
    logic enS, vddLowS, vsFaultS;
    logic newWrite;

    // Two flops per crossing signal, no logic in between
    always_ff @(posedge mclk) begin
        if (rst) begin
            reqS1_q <= 1'b0;
            reqS2_q <= 1'b0;
            ackSeen_q <= 1'b0;
            pinS1_q <= 3'h0;
            pinS2_q <= 3'h0;
        end else begin
            reqS1_q <= reqTgl_q;
            reqS2_q <= reqS1_q;
            ackSeen_q <= reqS2_q;
            pinS1_q <= {enPin, vddLow, vsFault};
            pinS2_q <= pinS1_q;
        end
    end

    assign enS = pinS2_q[2];
    assign vddLowS = pinS2_q[1];
    assign vsFaultS = pinS2_q[0];
    // Link data is stable while the toggle is unacknowledged
    assign newWrite = (reqS2_q != ackSeen_q);

    // ------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------
    hbp_mode_t state_q, state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            MODE_OFF, MODE_SLEEP, MODE_NORMAL: begin
                if (vddLowS) begin
                    state_d = MODE_OFF;
                end else if (!enS) begin
                    state_d = MODE_SLEEP;
                end else begin
                    state_d = MODE_NORMAL;
                end
            end
            default: state_d = MODE_OFF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= MODE_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Settings written by the host
    // ------------------------------------------------------------
    logic [7:0] actHi_q, actHi_d; // High switch activation per bridge
    logic [7:0] actLo_q, actLo_d; // Low switch activation per bridge
    logic [15:0] sel_q, sel_d; // Channel per bridge, 2 bits each
    logic [5:0] freq_q, freq_d; // Codes of channels 1..3
    logic [7:0] fwSel_q, fwSel_d; // 1 = active free-wheel
    logic [23:0] duty_q, duty_d; // Duties of channels 1..3
    logic flag_q, flag_d;

    // Writes count only in normal mode; other modes wipe everything.
    // A motor supply fault does not touch these.
    always_comb begin
        actHi_d = actHi_q;
        actLo_d = actLo_q;
        sel_d = sel_q;
        freq_d = freq_q;
        fwSel_d = fwSel_q;
        duty_d = duty_q;
        flag_d = flag_q;
        if (state_q != MODE_NORMAL) begin
            // Sleep or undervoltage: settings and flag cleared
            actHi_d = ACT_RST;
            actLo_d = ACT_RST;
            sel_d = {8{SEL_NONE}};
            freq_d = {3{FRQ_OFF}};
            fwSel_d = FW_RST;
            duty_d = {3{DUTY_RST}};
            flag_d = 1'b0;
        end else if (newWrite) begin
            if (linkIdx_q == IDX_ACT_HI) begin
                actHi_d = linkData_q;
            end else if (linkIdx_q == IDX_ACT_LO) begin
                actLo_d = linkData_q;
            end else if (linkIdx_q == IDX_SEL_A) begin
                sel_d[7:0] = linkData_q;
            end else if (linkIdx_q == IDX_SEL_B) begin
                sel_d[15:8] = linkData_q;
            end else if (linkIdx_q == IDX_FREQ) begin
                freq_d = linkData_q[5:0];
            end else if (linkIdx_q == IDX_FW) begin
                fwSel_d = linkData_q;
            end else if (linkIdx_q == IDX_DUTY1) begin
                duty_d[7:0] = linkData_q;
            end else if (linkIdx_q == IDX_DUTY2) begin
                duty_d[15:8] = linkData_q;
            end else if (linkIdx_q == IDX_DUTY3) begin
                duty_d[23:16] = linkData_q;
            end else if (linkIdx_q == IDX_FLAG) begin
                // Host sets the flag to notice a later reset
                flag_d = linkData_q[0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            // Power-on reset erases all settings
            actHi_q <= ACT_RST;
            actLo_q <= ACT_RST;
            sel_q <= {8{SEL_NONE}};
            freq_q <= {3{FRQ_OFF}};
            fwSel_q <= FW_RST;
            duty_q <= {3{DUTY_RST}};
            flag_q <= 1'b0;
        end else begin
            actHi_q <= actHi_d;
            actLo_q <= actLo_d;
            sel_q <= sel_d;
            freq_q <= freq_d;
            fwSel_q <= fwSel_d;
            duty_q <= duty_d;
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------
    // PWM channels
    // ------------------------------------------------------------
    logic [2:0] pwmOn, chRun, chFwOk;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        hbp_pwm_channel u_ch (
            .mclk(mclk),
            .rst(rst),
            .freqCode(freq_q[2*c +: 2]),
            .duty(duty_q[8*c +: 8]),
            .pwmOn(pwmOn[c]),
            .running(chRun[c]),
            .fwOk(chFwOk[c])
        );
    end

    // ------------------------------------------------------------
    // Switch requests and dead time
    // ------------------------------------------------------------
    logic [7:0] hsOut_q, hsOut_d;
    logic [7:0] lsOut_q, lsOut_d;
    logic [7:0] lastLow_q, lastLow_d; // Last switch on was the low one
    logic [7:0] gap_q [NB], gap_d [NB]; // Cycles with both switches off
    logic outEn;

    // Outputs only in normal mode with a healthy motor supply
    assign outEn = (state_q == MODE_NORMAL) && !vsFaultS;

    always_comb begin
        logic hsReq;
        logic lsReq;
        logic fwAct;
        int k;
        hsReq = 1'b0;
        lsReq = 1'b0;
        fwAct = 1'b0;
        k = 0;
        for (int b = 0; b < NB; b++) begin
            hsReq = 1'b0;
            lsReq = 1'b0;
            if (sel_q[2*b +: 2] == SEL_NONE) begin
                // Continuous drive straight from activation
                hsReq = actHi_q[b];
                lsReq = actLo_q[b];
            end else begin
                k = int'(sel_q[2*b +: 2]) - 1;
                fwAct = fwSel_q[b] && chFwOk[k];
                if (actHi_q[b] && !actLo_q[b]) begin
                    hsReq = chRun[k] && pwmOn[k];
                    if (chRun[k]) begin
                        lsReq = fwAct && !pwmOn[k];
                    end else begin
                        lsReq = fwSel_q[b];
                    end
                end else if (actLo_q[b] && !actHi_q[b]) begin
                    lsReq = chRun[k] && pwmOn[k];
                    hsReq = chRun[k] && fwAct && !pwmOn[k];
                end
            end
            // Never ask for both at once
            if ((hsReq && lsReq) || !outEn) begin
                hsReq = 1'b0;
                lsReq = 1'b0;
            end
            // Turn on only after the opposite switch has been off long enough
            hsOut_d[b] = hsReq && !lsOut_q[b]
                && (hsOut_q[b] || !lastLow_q[b] || gap_q[b] >= DT_LH_CYC);
            lsOut_d[b] = lsReq && !hsOut_q[b]
                && (lsOut_q[b] || lastLow_q[b] || gap_q[b] >= DT_HL_CYC);
            // Which switch was on last decides which dead time applies
            lastLow_d[b] = lsOut_q[b] || (lastLow_q[b] && !hsOut_q[b]);
            // Off-time count saturates so a long idle never wraps to zero
            gap_d[b] = (hsOut_q[b] || lsOut_q[b]) ? 8'h00
                : gap_q[b] + {7'h00, gap_q[b] != GAP_MAX};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hsOut_q <= 8'h00;
            lsOut_q <= 8'h00;
            lastLow_q <= 8'h00;
            for (int b = 0; b < NB; b++) begin
                gap_q[b] <= 8'h00;
            end
        end else begin
            hsOut_q <= hsOut_d;
            lsOut_q <= lsOut_d;
            lastLow_q <= lastLow_d;
            for (int b = 0; b < NB; b++) begin
                gap_q[b] <= gap_d[b];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign highSwitch = hsOut_q;
    assign lowSwitch = lsOut_q;
    assign normalMode = (state_q == MODE_NORMAL);
    assign chargePumpOn = (state_q == MODE_NORMAL);
    assign resetSeenFlag = flag_q;
    assign chanRunning = chRun;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_enDrop;
        !enS ##1 state_q == MODE_SLEEP;
    endsequence

    a_sleep_off: assert property (@(posedge mclk) disable iff (rst)
        s_enDrop |=> highSwitch == 8'h00 && lowSwitch == 8'h00 && actHi_q == ACT_RST)
        else $error("outputs or settings alive in sleep");
    a_no_shoot: assert property (@(posedge mclk) disable iff (rst)
        (highSwitch & lowSwitch) == 8'h00)
        else $error("both switches of a bridge on");
    a_dead_gap: assert property (@(posedge mclk) disable iff (rst)
        $rose(hsOut_q[1]) && $past(lastLow_q[1]) |-> $past(gap_q[1]) >= DT_LH_CYC)
        else $error("dead time too short on bridge 2");
    a_flag_por: assert property (@(posedge mclk)
        rst |=> !resetSeenFlag)
        else $error("flag set after power-on reset");
    a_vs_keep: assert property (@(posedge mclk) disable iff (rst)
        vsFaultS && state_q == MODE_NORMAL && !newWrite |=> $stable(actHi_q) && $stable(sel_q))
        else $error("settings lost on motor supply fault");
    a_uv_ignore: assert property (@(posedge mclk) disable iff (rst)
        state_q == MODE_OFF |=> flag_q == 1'b0 && freq_q == 6'h00 && highSwitch == 8'h00)
        else $error("undervoltage did not clear state");
    a_steady_on: assert property (@(posedge mclk) disable iff (rst)
        outEn && sel_q[1:0] == SEL_NONE && actHi_q[0] && !actLo_q[0] && hsOut_q[0]
            && $stable(actHi_q) && $stable(sel_q) && $stable(outEn) |=> hsOut_q[0])
        else $error("continuous switch dropped");
endmodule

// ### src/hbp_pwm_channel.sv
// One PWM channel: step prescaler, 256-step counter, shadowed settings.
// Assumes freqCode and duty are stable registers on mclk.
`timescale 1ns/1ps
module hbp_pwm_channel
    import hbp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] freqCode,
    input wire logic [7:0] duty,
    output logic pwmOn,
    output logic running,
    output logic fwOk
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0] code_q, code_d; // Code in use this period
    logic [7:0] duty_q, duty_d; // Duty in use this period
    logic [9:0] pre_q, pre_d; // Clocks within a step
    logic [7:0] step_q, step_d; // Step within the period
    logic run_q, run_d;
    logic pwm_q, pwm_d;
    logic fw_q, fw_d;

    // Both switches must get more than the two dead times
    function automatic logic fw_effective(input logic [7:0] d, input logic [1:0] c);
        int p;
        p = int'(hbp_prescale(c));
        return (int'(d) * p > DT_SUM_CYC) && ((STEPS - int'(d)) * p > DT_SUM_CYC);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        code_d = code_q;
        duty_d = duty_q;
        pre_d = pre_q;
        step_d = step_q;
        run_d = run_q;
        if (freqCode == FRQ_OFF) begin
            // Stop at once and hold off
            run_d = 1'b0;
            code_d = FRQ_OFF;
            pre_d = 10'h000;
            step_d = 8'h00;
        end else if (!run_q) begin
            // Nonzero code starts a fresh period
            run_d = 1'b1;
            code_d = freqCode;
            duty_d = duty;
            pre_d = 10'h000;
            step_d = 8'h00;
        end else if (pre_q == hbp_prescale(code_q) - 10'h001) begin
            pre_d = 10'h000;
            step_d = step_q + 8'h01;
            // New settings only at the period boundary, so no runt pulses
            if (step_q == STEP_LAST) begin
                code_d = freqCode;
                duty_d = duty;
            end
        end else begin
            pre_d = pre_q + 10'h001;
        end
        // On for duty of the 256 steps
        pwm_d = run_d && (step_d < duty_d);
        fw_d = run_d && fw_effective(duty_d, code_d);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            code_q <= FRQ_OFF;
            duty_q <= DUTY_RST;
            pre_q <= 10'h000;
            step_q <= 8'h00;
            run_q <= 1'b0;
            pwm_q <= 1'b0;
            fw_q <= 1'b0;
        end else begin
            code_q <= code_d;
            duty_q <= duty_d;
            pre_q <= pre_d;
            step_q <= step_d;
            run_q <= run_d;
            pwm_q <= pwm_d;
            fw_q <= fw_d;
        end
    end

    assign pwmOn = pwm_q;
    assign running = run_q;
    assign fwOk = fw_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Cycles spent in the current step, counted apart from the prescaler
    logic [9:0] stepCnt_q, stepCnt_d;

    // Restarts whenever the step moves or the channel starts or stops
    always_comb begin
        stepCnt_d = stepCnt_q + 10'h001;
        if (!run_q || !run_d || step_d != step_q) begin
            stepCnt_d = 10'h000;
        end
    end

    // Step cycle counter register
    always_ff @(posedge mclk) begin
        if (rst) begin
            stepCnt_q <= 10'h000;
        end else begin
            stepCnt_q <= stepCnt_d;
        end
    end

    sequence s_periodEnd;
        run_q && freqCode != FRQ_OFF && step_q == STEP_LAST
            && pre_q == hbp_prescale(code_q) - 10'h001;
    endsequence

    a_shadow_load: assert property (@(posedge mclk) disable iff (rst)
        s_periodEnd |=> duty_q == $past(duty) && step_q == 8'h00)
        else $error("duty not reloaded at period end");
    a_stop_off: assert property (@(posedge mclk) disable iff (rst)
        freqCode == FRQ_OFF |=> !pwmOn && !running && step_q == 8'h00)
        else $error("stopped channel still active");
    a_step_len: assert property (@(posedge mclk) disable iff (rst)
        run_q && run_d && code_q == FRQ_200 && step_d != step_q
            |-> stepCnt_q == PRE_200 - 10'h001)
        else $error("200 Hz step length wrong");
endmodule

// ### verif/hbp_host_model.sv
// Host model: sends single-register writes over the link clock.
// Assumes the controller answers with cfgReady in the linkClk domain.
`timescale 1ns/1ps
module hbp_host_model (
    input wire logic linkClk,
    input wire logic cfgReady,
    output logic cfgWrite,
    output logic [3:0] cfgIndex,
    output logic [7:0] cfgData
);
    // Idle lines carry no copy of the last value
    initial begin
        cfgWrite = 1'b0;
        cfgIndex = 4'hF;
        cfgData = 8'h00;
    end
    // One write at a time, in the caller's order
    // A nonzero gap makes the host slow to start the write
    task automatic wr(input logic [3:0] idx, input logic [7:0] dat, input int gap,
        output bit ok);
        int n;
        ok = 1'b0;
        repeat (gap + 1) @(posedge linkClk);
        #1;
        cfgWrite = 1'b1;
        cfgIndex = idx;
        cfgData = dat;
        @(posedge linkClk);
        #1;
        cfgWrite = 1'b0;
        cfgIndex = ~idx;
        cfgData = ~dat;
        // Bounded wait for the acknowledge to return
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge linkClk);
            #1;
            ok = (cfgReady === 1'b1);
        end
    endtask
endmodule

// ### verif/test_half_bridge_pwm_mode_control.sv
// Bench: link writes, modes, continuous and PWM switch drive.
// Assumes hbp_host_model on the link side; pins driven 2 ns after mclk.
`timescale 1ns/1ps
module test_half_bridge_pwm_mode_control;
    import hbp_pkg::*;
    // ----
    // Clocks, pins, counters
    // ----
    logic mclk = 0, linkClk = 0, rst = 1, linkRst = 1;
    logic enPin = 1, vddLow = 0, vsFault = 0;
    logic cfgWrite, cfgReady, chargePumpOn, normalMode, resetSeenFlag;
    logic [3:0] cfgIndex;
    logic [7:0] cfgData, highSwitch, lowSwitch;
    logic [2:0] chanRunning;
    int error_cnt = 0, cmp_count = 0, ticks = 0, i, bad = 0;
    initial forever #25 mclk = ~mclk;
    // Odd phase keeps link edges off the stimulus instants
    initial begin
        #33;
        forever #80 linkClk = ~linkClk;
    end
    hbp_bridge_ctrl uut (.mclk(mclk), .rst(rst), .enPin(enPin), .vddLow(vddLow),
        .vsFault(vsFault), .linkClk(linkClk), .linkRst(linkRst), .cfgWrite(cfgWrite),
        .cfgIndex(cfgIndex), .cfgData(cfgData), .cfgReady(cfgReady),
        .highSwitch(highSwitch), .lowSwitch(lowSwitch), .chargePumpOn(chargePumpOn),
        .normalMode(normalMode), .resetSeenFlag(resetSeenFlag), .chanRunning(chanRunning));
    hbp_host_model host (.linkClk(linkClk), .cfgReady(cfgReady), .cfgWrite(cfgWrite),
        .cfgIndex(cfgIndex), .cfgData(cfgData));
    // ----
    // Tasks
    // ----
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [3:0] idx, input logic [7:0] dat, input int gap);
        bit ok;
        host.wr(idx, dat, gap, ok);
        chk(16'(ok), 16'h1);
        cyc(1);
    endtask
    task automatic wrap_up();
        $display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard: whole run needs about 1700 cycles
    always @(posedge mclk) begin
        ticks <= ticks + 1;
        if (ticks == 12000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // ----
    // Main sequence
    // ----
    initial begin
        cyc(16);
        rst = 0;
        linkRst = 0;
        chk({highSwitch, lowSwitch}, 16'h0);
        chk(16'(resetSeenFlag), 16'h0);
        cyc(5);
        chk(16'({chargePumpOn, normalMode}), 16'h3);
        w(IDX_ACT_HI, 8'h01, 0);
        cyc(30);
        for (i = 0; i < 200; i++) begin
            cyc(1);
            bad += int'(highSwitch !== 8'h01);
        end
        chk(16'(bad), 16'h0);
        vsFault = 1;
        cyc(10);
        chk(16'(highSwitch), 16'h0);
        vsFault = 0;
        cyc(30);
        chk(16'(highSwitch), 16'h1);
        // PWM on bridge 2, channel 1, duty 2 steps at 200 Hz
        w(IDX_FREQ, 8'h00, 0);
        w(IDX_FW, 8'h00, 3);
        w(IDX_SEL_A, 8'h04, 0);
        w(IDX_DUTY1, 8'h02, 0);
        w(IDX_FREQ, 8'h03, 0);
        w(IDX_ACT_HI, 8'h03, 0);
        cyc(100);
        chk(16'(highSwitch), 16'h3);
        chk(16'(chanRunning), 16'h1);
        cyc(900);
        chk(16'(highSwitch), 16'h1);
        chk(16'(lowSwitch), 16'h0);
        // Active free-wheel: bridge 2 low switch carries the off phase
        w(IDX_FW, 8'h02, 0);
        cyc(30);
        chk(16'(lowSwitch), 16'h2);
        w(IDX_FREQ, 8'h00, 0);
        cyc(10);
        chk(16'(chanRunning), 16'h0);
        chk({highSwitch, lowSwitch}, 16'h0102);
        // Restart: the high switch waits out the dead time after the low one
        w(IDX_FREQ, 8'h03, 0);
        cyc(100);
        chk({highSwitch, lowSwitch}, 16'h0300);
        w(IDX_FLAG, 8'h01, 0);
        cyc(10);
        chk(16'(resetSeenFlag), 16'h1);
        enPin = 0;
        cyc(10);
        chk(16'({normalMode, highSwitch}), 16'h0);
        enPin = 1;
        cyc(10);
        chk(16'({normalMode, resetSeenFlag, highSwitch}), 16'h200);
        w(IDX_ACT_HI, 8'h01, 0);
        cyc(30);
        chk(16'(highSwitch), 16'h1);
        vddLow = 1;
        cyc(10);
        chk(16'({normalMode, highSwitch}), 16'h0);
        w(IDX_ACT_HI, 8'h01, 0);
        vddLow = 0;
        cyc(30);
        chk(16'({normalMode, highSwitch}), 16'h100);
        wrap_up();
    end
endmodule
